// *** logic/boundary_scan_test_port.sv ***
// Boundary-scan test access port with boundary register and pin override
//
// Behaviour
// - Standard TAP state machine and protocol.
// - Instruction register is three bits.
// - Bypass puts one-bit register between TDI, TDO.
// - Sample captures pin snapshot, no disturbance.
// - Sample/preload holds shifted pattern for later driving.
// - Extest drives boundary pattern onto output pins.
// - Extest captures input pin values for shifting.
// - Boundary length parameter 522, 621 or 666.
// - No scan while configuration in progress.
// - Undriven test inputs read as high.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port
    import scan_port_pkg::*;
#(
    parameter int CELLS      = CELLS_LARGE,
    parameter int FIFO_DEPTH = PATTERN_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             tmsFloat,
    input  wire logic             tdiFloat,
    input  wire logic             configBusy,
    input  wire logic [CELLS-1:0] pinSense,
    input  wire logic [CELLS-1:0] coreOut,
    input  wire logic             patternReady,
    output logic                  tdoOut,
    output logic                  tdoEnableN,
    output logic      [CELLS-1:0] pinOut,
    output logic                  pinOutSel
);
    // Link-side (tck) signals
    logic             rstTckMeta;
    logic             rstTck;
    logic             busyMeta;
    logic             busyTck;
    logic [CELLS-1:0] senseMeta;
    logic [CELLS-1:0] senseTck;
    logic             ackMeta;
    logic             ackTck;
    tap_state_e       tapState;
    tap_state_e       next_tapState;
    logic             effTms;
    logic             effTdi;
    logic [IR_LEN-1:0] irShift;
    logic [IR_LEN-1:0] irActive;
    instr_e           instr;
    logic             bypassBit;
    logic [CELLS-1:0] bsr;
    logic [CELLS-1:0] holdPattern;
    logic             reqToggle;
    logic             handoffBusy;
    logic             extestTck;

    // Core-side (ref_clk) signals
    logic             reqMeta;
    logic             reqSync;
    logic             reqSeen;
    logic             extestMeta;
    logic             extestRef;
    logic             fifoInValid;
    logic             fifoInReady;
    logic             fifoOutValid;
    logic [CELLS-1:0] fifoOutData;
    logic [CELLS-1:0] drivePattern;

    // Pull-ups: a floating pin is seen as one
    assign effTms = tms | tmsFloat;
    assign effTdi = tdi | tdiFloat;

    always_ff @(posedge tck) begin
        rstTckMeta <= rst;
        rstTck     <= rstTckMeta;
    end

    always_ff @(posedge tck) begin
        busyMeta <= configBusy;
        busyTck  <= busyMeta;
    end

    // Pins are asynchronous to tck, so every cell is synchronised
    always_ff @(posedge tck) begin
        senseMeta <= pinSense;
        senseTck  <= senseMeta;
    end

    always_ff @(posedge tck) begin
        ackMeta <= reqSeen;
        ackTck  <= ackMeta;
    end

    // Controller state machine
    always_comb begin
        next_tapState = tapState;
        unique case (tapState)
            TEST_LOGIC_RESET: begin
                next_tapState = effTms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            end
            RUN_TEST_IDLE: begin
                next_tapState = effTms ? SELECT_DR : RUN_TEST_IDLE;
            end
            SELECT_DR: begin
                next_tapState = effTms ? SELECT_IR : CAPTURE_DR;
            end
            CAPTURE_DR: begin
                next_tapState = effTms ? EXIT1_DR : SHIFT_DR;
            end
            SHIFT_DR: begin
                next_tapState = effTms ? EXIT1_DR : SHIFT_DR;
            end
            EXIT1_DR: begin
                next_tapState = effTms ? UPDATE_DR : PAUSE_DR;
            end
            PAUSE_DR: begin
                next_tapState = effTms ? EXIT2_DR : PAUSE_DR;
            end
            EXIT2_DR: begin
                next_tapState = effTms ? UPDATE_DR : SHIFT_DR;
            end
            UPDATE_DR: begin
                next_tapState = effTms ? SELECT_DR : RUN_TEST_IDLE;
            end
            SELECT_IR: begin
                next_tapState = effTms ? TEST_LOGIC_RESET : CAPTURE_IR;
            end
            CAPTURE_IR: begin
                next_tapState = effTms ? EXIT1_IR : SHIFT_IR;
            end
            SHIFT_IR: begin
                next_tapState = effTms ? EXIT1_IR : SHIFT_IR;
            end
            EXIT1_IR: begin
                next_tapState = effTms ? UPDATE_IR : PAUSE_IR;
            end
            PAUSE_IR: begin
                next_tapState = effTms ? EXIT2_IR : PAUSE_IR;
            end
            EXIT2_IR: begin
                next_tapState = effTms ? UPDATE_IR : SHIFT_IR;
            end
            UPDATE_IR: begin
                next_tapState = effTms ? SELECT_DR : RUN_TEST_IDLE;
            end
        endcase
    end

    // Configuration pins the port in reset, so no scan can start
    always_ff @(posedge tck) begin
        if (rstTck || busyTck) begin
            tapState <= TEST_LOGIC_RESET;
        end else begin
            tapState <= next_tapState;
        end
    end

    // Instruction register
    always_ff @(posedge tck) begin
        if (rstTck || busyTck || tapState == TEST_LOGIC_RESET) begin
            irShift <= IR_CAPTURE;
        end else if (tapState == CAPTURE_IR) begin
            irShift <= IR_CAPTURE;
        end else if (tapState == SHIFT_IR) begin
            irShift <= {effTdi, irShift[IR_LEN-1:1]};
        end
    end

    always_ff @(posedge tck) begin
        if (rstTck || busyTck || tapState == TEST_LOGIC_RESET) begin
            irActive <= OP_BYPASS;
        end else if (tapState == UPDATE_IR) begin
            irActive <= irShift;
        end
    end

    always_comb begin
        unique case (irActive)
            OP_EXTEST: instr = SEL_EXTEST;
            OP_SAMPLE: instr = SEL_SAMPLE;
            default:   instr = SEL_BYPASS;
        endcase
    end

    // Bypass register
    always_ff @(posedge tck) begin
        if (rstTck) begin
            bypassBit <= BYPASS_CAPTURE;
        end else if (instr == SEL_BYPASS && tapState == CAPTURE_DR) begin
            bypassBit <= BYPASS_CAPTURE;
        end else if (instr == SEL_BYPASS && tapState == SHIFT_DR) begin
            bypassBit <= effTdi;
        end
    end

    // Boundary register, one shift stage per cell
    always_ff @(posedge tck) begin
        if (rstTck) begin
            bsr <= '0;
        end else if (instr != SEL_BYPASS && tapState == CAPTURE_DR) begin
            bsr <= senseTck;
        end else if (instr != SEL_BYPASS && tapState == SHIFT_DR) begin
            bsr <= {effTdi, bsr[CELLS-1:1]};
        end
    end

    // Pattern handoff toward the core clock
    assign handoffBusy = (reqToggle != ackTck);

    // An update while the previous pattern is still in flight is dropped;
    // overwriting the held word would tear it mid-crossing
    always_ff @(posedge tck) begin
        if (rstTck) begin
            holdPattern <= '0;
        end else if (instr != SEL_BYPASS && tapState == UPDATE_DR && !handoffBusy) begin
            holdPattern <= bsr;
        end
    end

    // Toggle moves on the same tck edge that loads the word into holdPattern
    always_ff @(posedge tck) begin
        if (rstTck) begin
            reqToggle <= 1'b0;
        end else if (instr != SEL_BYPASS && tapState == UPDATE_DR && !handoffBusy) begin
            reqToggle <= ~reqToggle;
        end
    end

    // Set with the instruction itself: tck may stop right after Update-IR
    always_ff @(posedge tck) begin
        if (rstTck || busyTck || tapState == TEST_LOGIC_RESET) begin
            extestTck <= 1'b0;
        end else if (tapState == UPDATE_IR) begin
            extestTck <= (irShift == OP_EXTEST);
        end
    end

    // Serial output changes on the falling edge, per the port protocol
    always_ff @(negedge tck) begin
        if (rstTck) begin
            tdoOut <= 1'b0;
        end else if (tapState == SHIFT_IR) begin
            tdoOut <= irShift[0];
        end else if (tapState == SHIFT_DR) begin
            tdoOut <= (instr == SEL_BYPASS) ? bypassBit : bsr[0];
        end
    end

    // Released outside shift so other chain members can drive the line
    always_ff @(negedge tck) begin
        if (rstTck) begin
            tdoEnableN <= 1'b1;
        end else begin
            tdoEnableN <= !(tapState == SHIFT_IR || tapState == SHIFT_DR);
        end
    end

    // Core clock side
    always_ff @(posedge ref_clk) begin
        reqMeta <= reqToggle;
        reqSync <= reqMeta;
    end

    always_ff @(posedge ref_clk) begin
        extestMeta <= extestTck;
        extestRef  <= extestMeta;
    end

    assign fifoInValid = (reqSync != reqSeen);

    // Acknowledge only once the FIFO took the word: a full FIFO stalls the handoff
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reqSeen <= 1'b0;
        end else if (fifoInValid && fifoInReady) begin
            reqSeen <= reqSync;
        end
    end

    pattern_fifo #(
        .WIDTH (CELLS),
        .DEPTH (FIFO_DEPTH)
    ) u_pattern_fifo (
        .clk      (ref_clk),
        .rst      (rst),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (holdPattern),
        .outValid (fifoOutValid),
        .outReady (patternReady),
        .outData  (fifoOutData)
    );

    // Preloaded pattern waits here until extest selects it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drivePattern <= '0;
        end else if (fifoOutValid && patternReady) begin
            drivePattern <= fifoOutData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinOut <= '0;
        end else begin
            pinOut <= extestRef ? drivePattern : coreOut;
        end
    end

    // Same select as the pin mux, so the flag never leads the data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinOutSel <= 1'b0;
        end else begin
            pinOutSel <= extestRef;
        end
    end
endmodule : boundary_scan_test_port
`default_nettype wire

// *** logic/scan_port_pkg.sv ***
// Shared constants and types for the pin scan test port
package scan_port_pkg;
    localparam int          IR_LEN        = 3;
    localparam logic [2:0]  OP_EXTEST     = 3'h0;
    localparam logic [2:0]  OP_SAMPLE     = 3'h5;
    localparam logic [2:0]  OP_BYPASS     = 3'h7;
    localparam logic [2:0]  IR_CAPTURE    = 3'h1;
    localparam int          CELLS_SMALL   = 522;
    localparam int          CELLS_MID     = 621;
    localparam int          CELLS_LARGE   = 666;
    localparam int          PATTERN_DEPTH = 8;
    localparam logic        BYPASS_CAPTURE = 1'b0;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_e;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_SAMPLE, SEL_EXTEST
    } instr_e;
endpackage : scan_port_pkg

// *** logic/pattern_fifo.sv ***
// Small synchronous FIFO for boundary patterns
`timescale 1ns/1ps
`default_nettype none
module pattern_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic             full;
    logic             empty;

    // Depth must be a power of two; pointers carry one wrap bit
    assign empty    = (wrPtr == rdPtr);
    assign full     = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (inValid && !full) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
        end else if (inValid && !full) begin
            wrPtr <= wrPtr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdPtr <= '0;
        end else if (outReady && !empty) begin
            rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule : pattern_fifo
`default_nettype wire

// *** testbench/scan_port_assertions.sv ***
// Pin-level checks for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module scan_port_checker
    import scan_port_pkg::*;
#(
    parameter int CELLS = CELLS_LARGE
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tmsFloat,
    input wire logic             configBusy,
    input wire logic [CELLS-1:0] coreOut,
    input wire logic             tdoOut,
    input wire logic             tdoEnableN,
    input wire logic [CELLS-1:0] pinOut,
    input wire logic             pinOutSel
);
    sequence busyRun;
        configBusy [*6];
    endsequence
    sequence floatRun;
        tmsFloat [*5];
    endsequence
    chk_reset_clears:
    assert property (@(posedge ref_clk) rst |=> pinOut == '0 && !pinOutSel)
        else $error("pins not cleared by reset");
    chk_core_passes:
    assert property (@(posedge ref_clk) disable iff (rst)
        !pinOutSel && !$past(rst) |-> pinOut == $past(coreOut))
        else $error("core value not passed to pins");
    chk_config_tdo:
    assert property (@(posedge tck) disable iff (rst) configBusy [*4] |=> tdoEnableN)
        else $error("serial out enabled during configuration");
    chk_config_pins:
    assert property (@(posedge tck) disable iff (rst) busyRun |-> ##2 !pinOutSel)
        else $error("pattern still driven during configuration");
    chk_shift_stays:
    assert property (@(posedge tck) disable iff (rst)
        !tdoEnableN && !tms && !tmsFloat && !configBusy |=> !tdoEnableN)
        else $error("shift left with mode low");
    chk_shift_exits:
    assert property (@(posedge tck) disable iff (rst)
        !tdoEnableN && tms && !configBusy |=> tdoEnableN)
        else $error("shift kept with mode high");
    chk_tdo_quiet:
    assert property (@(negedge tck) disable iff (rst)
        tdoEnableN && $past(tdoEnableN) |-> $stable(tdoOut))
        else $error("serial out moved outside shift");
    chk_float_reset:
    assert property (@(posedge tck) disable iff (rst) floatRun |=> tdoEnableN)
        else $error("floating mode did not reach reset");
endmodule : scan_port_checker
bind boundary_scan_test_port scan_port_checker #(.CELLS(CELLS)) checker_i (
    .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tmsFloat(tmsFloat),
    .configBusy(configBusy), .coreOut(coreOut), .tdoOut(tdoOut),
    .tdoEnableN(tdoEnableN), .pinOut(pinOut), .pinOutSel(pinOutSel));
`default_nettype wire

// *** testbench/scan_controller.sv ***
// External test controller driving the scan port
`timescale 1ns/1ps
`default_nettype none
module scan_controller #(
    parameter int N = 522
) (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      tdiFloat,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        tdiFloat = 1'b1;
    end
    // Link clock only runs inside frames
    task automatic bitx(input logic m, input logic d, output logic o);
        #0.7 tms = m;
        tdi = d;
        tdiFloat = 1'b0;
        #14.3 tck = 1'b1;
        o = tdo;
        #15 tck = 1'b0;
    endtask : bitx
    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) bitx(seq[i], 1'b0, o);
        tdiFloat = 1'b1;
        tdi = ~tdi;
    endtask : walk
    task automatic shiftIr(input logic [2:0] op, output logic [2:0] cap);
        walk(8'h03, 4);
        for (int i = 0; i < 3; i++) bitx(i == 2, op[i], cap[i]);
        walk(8'h01, 2);
    endtask : shiftIr
    task automatic shiftDr(input logic [N-1:0] d, output logic [N-1:0] q);
        walk(8'h01, 3);
        for (int i = 0; i < N; i++) bitx(i == N - 1, d[i], q[i]);
        walk(8'h01, 2);
    endtask : shiftDr
endmodule : scan_controller
`default_nettype wire

// *** testbench/boundary_scan_test_port_tb.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module boundary_scan_test_port_tb;
    import scan_port_pkg::*;
    localparam int CELLS = CELLS_SMALL;
    logic ref_clk, rst, tck, tms, tdi, tmsFloat, tdiFloat, configBusy, patternReady;
    logic tdoOut, tdoEnableN, pinOutSel, tdoLine, byp, sel;
    logic [CELLS-1:0] pinSense, coreOut, pinOut, din, dout, want, last;
    logic [2:0]       op, cap;
    int               fails = 0;
    int               totalChecks = 0;
    // Opcode, bypass expected, pins taken
    logic [4:0] rows [8] = '{{OP_SAMPLE, 2'b00}, {OP_EXTEST, 2'b01}, 5'h06, 5'h0A,
                             5'h0E, 5'h12, 5'h1A, {OP_BYPASS, 2'b10}};
    // Released serial out reads high through its pull-up
    assign tdoLine = tdoEnableN ? 1'b1 : tdoOut;
    scan_controller #(.N(CELLS)) ctl (.tck(tck), .tms(tms), .tdi(tdi),
        .tdiFloat(tdiFloat), .tdo(tdoLine));
    boundary_scan_test_port #(.CELLS(CELLS)) dut (.ref_clk(ref_clk), .rst(rst),
        .tck(tck), .tms(tms), .tdi(tdi), .tmsFloat(tmsFloat), .tdiFloat(tdiFloat),
        .configBusy(configBusy), .pinSense(pinSense), .coreOut(coreOut),
        .patternReady(patternReady), .tdoOut(tdoOut), .tdoEnableN(tdoEnableN),
        .pinOut(pinOut), .pinOutSel(pinOutSel));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic waitRef(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : waitRef
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : printVerdict
    initial begin
        #380000;
        fails++;
        $display("watchdog expired");
        printVerdict();
    end
    initial begin
        rst = 1'b1;
        configBusy = 1'b0;
        tmsFloat = 1'b0;
        patternReady = 1'b1;
        pinSense = {87{6'h1E}};
        coreOut = {87{6'h33}};
        ctl.walk(8'hFF, 6);
        waitRef(1);
        rst = 1'b0;
        ctl.walk(8'h1F, 5);
        ctl.walk(8'h00, 1);
        `CHK("reset pins", 1'b0, pinOutSel)
        foreach (rows[r]) begin
            {op, byp, sel} = rows[r];
            ctl.shiftIr(op, cap);
            `CHK("ir capture", IR_CAPTURE, cap)
            waitRef(40);
            `CHK("pin select", sel, pinOutSel)
            if (sel) `CHK("preload", last, pinOut)
            else `CHK("core pass", coreOut, pinOut)
            din = {87{6'h2D ^ 6'(r)}};
            want = byp ? {din[CELLS-2:0], BYPASS_CAPTURE} : pinSense;
            ctl.shiftDr(din, dout);
            `CHK("dr out", want, dout)
            waitRef(40);
            if (sel) `CHK("extest drive", din, pinOut)
            last = din;
            $display("row %0d done", r);
        end
        // Busy configuration must drop a live pattern
        ctl.shiftIr(OP_EXTEST, cap);
        waitRef(40);
        configBusy = 1'b1;
        ctl.walk(8'h00, 8);
        ctl.shiftIr(OP_EXTEST, cap);
        waitRef(40);
        `CHK("busy lock", 1'b0, pinOutSel)
        `CHK("busy tdo", 1'b1, tdoEnableN)
        configBusy = 1'b0;
        ctl.walk(8'h00, 3);
        ctl.shiftIr(OP_EXTEST, cap);
        waitRef(40);
        `CHK("after busy", 1'b1, pinOutSel)
        $display("config test done");
        tmsFloat = 1'b1;
        ctl.walk(8'h00, 5);
        tmsFloat = 1'b0;
        ctl.walk(8'h00, 1);
        waitRef(40);
        `CHK("float reset", 1'b0, pinOutSel)
        $display("float test done");
        printVerdict();
    end
endmodule : boundary_scan_test_port_tb
`default_nettype wire
